// ===== pkg/ivm_pkg.sv
// Overview of operation
// - trap vectors 80-255, no level, descending offsets
// - vector 22 shared by line 6, CAN wake
// - CAN sources exist only on CAN variants
// - delayed bit requests vector 63, offset 300h
// - timer1 compare clear requests vector 43
// - timer1 zero detect requests vector 44
// - timer2 compare clear requests vector 45
// - timer2 zero detect requests vector 46
// - timer0 compare clear requests vector 48
// - timer0 zero detect requests vector 49
// - vectors 64, 65 never requested by hardware
package ivm_pkg;
    // vector numbering
    localparam logic [7:0] VEC_FIRST_HW = 8'h10;
    localparam logic [7:0] VEC_TRAP_FIRST = 8'h50;
    localparam logic [7:0] VEC_RTOS_A = 8'h40;
    localparam logic [7:0] VEC_RTOS_B = 8'h41;
    localparam int N_SLOTS = 48;
    localparam logic [31:0] TABLE_TOP = 32'h0000_03FC;
    // table base after reset puts vector 0 at 000FFFFC
    localparam logic [31:0] BASE_RESET = 32'h000F_FC00;
    // slots: slot i serves vector 16+i
    localparam int SLOT_EXT6 = 6;
    localparam int SLOT_CAN = 19;
    localparam int SLOT_FRT1_CLEAR = 27;
    localparam int SLOT_FRT1_ZERO = 28;
    localparam int SLOT_FRT2_CLEAR = 29;
    localparam int SLOT_FRT2_ZERO = 30;
    localparam int SLOT_FRT0_CLEAR = 32;
    localparam int SLOT_FRT0_ZERO = 33;
    localparam int SLOT_DELAY = 47;
    // slots of vectors 36, 41, 50, 54, 56 never request
    localparam logic [47:0] SLOT_RESERVED_MASK = 48'h0144_0000_0000 | 48'h0000_0210_0000;
    // level registers
    localparam int LEVEL_W = 5;
    localparam logic [4:0] LEVEL_RESET = 5'h1F;
    // register offsets
    localparam logic [11:0] OFS_BASE = 12'h000;
    localparam logic [11:0] OFS_DELAY = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_CLEAR = 12'h00C;
    localparam logic [11:0] OFS_ENABLE = 12'h010;
    localparam logic [11:0] OFS_OFFER = 12'h014;
    localparam logic [11:0] OFS_LEVEL0 = 12'h100;
    localparam logic [11:0] OFS_LEVEL_END = 12'h1C0;
    // event bits of status, clear and enable
    localparam int EV_W = 3;
    localparam int EV_ACCEPT = 0;
    localparam int EV_TRAP = 1;
    localparam int EV_TRAP_BAD = 2;
    localparam logic [2:0] EV_RESET = 3'h0;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SCAN = 2'b01,
        ST_OFFER = 2'b11
    } scan_state_t;
    function automatic logic [31:0] fetch_addr(input logic [31:0] base, input logic [7:0] vec);
        fetch_addr = base + TABLE_TOP - {22'h0, vec, 2'b00};
    endfunction
endpackage

// ===== rtl/interrupt_vector_map.sv
`timescale 1ns/1ps
module interrupt_vector_map #(
    parameter bit HAS_CAN = 1'b1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // peripheral requests, bit i for vector 16+i
    input wire logic [47:0] periph_req,
    input wire logic can_req,
    input wire logic can_wake,
    input wire logic frt0_clear,
    input wire logic frt0_zero,
    input wire logic frt1_clear,
    input wire logic frt1_zero,
    input wire logic frt2_clear,
    input wire logic frt2_zero,
    // cpu exception entry
    input wire logic [4:0] cpu_level_mask,
    output logic cpu_irq_req,
    output logic [7:0] irq_vector,
    output logic [4:0] irq_level,
    output logic [31:0] irq_fetch_addr,
    input wire logic cpu_ack,
    // software traps
    input wire logic trap_req,
    input wire logic [7:0] trap_num,
    output logic trap_valid,
    output logic [7:0] trap_vector,
    output logic [31:0] trap_fetch_addr,
    // interrupt
    output logic irq
);
    logic [47:0] pend;
    logic lvl_hit;
    logic [5:0] lvl_idx;
    logic apb_owns;
    logic [5:0] mem_addr;
    logic mem_we;
    logic [4:0] mem_rdata;
    ivm_pkg::scan_state_t state, next_state;
    logic [5:0] idx, next_idx;
    logic rd_valid, next_rd_valid;
    logic [5:0] rd_idx, next_rd_idx;
    logic [4:0] best_lvl, next_best_lvl;
    logic [5:0] best_slot, next_best_slot;
    logic found, next_found;
    logic [7:0] next_irq_vector;
    logic [4:0] next_irq_level;
    logic [31:0] next_irq_fetch_addr;
    logic accept_ev;
    logic next_trap_valid;
    logic [7:0] next_trap_vector;
    logic [31:0] next_trap_fetch_addr;
    logic trap_bad_ev;
    logic [31:0] vector_table_base, next_vector_table_base;
    logic delay_bit, next_delay_bit;
    logic [2:0] status, next_status;
    logic [2:0] enable, next_enable;
    logic rd_wait, next_rd_wait;
    logic [31:0] next_prdata;
    logic mapped;
    logic acc;

    if (ivm_pkg::N_SLOTS != 48)
    begin : g_slot_check
        $error("slot count must be 48");
    end

    // request map
    always_comb
    begin
        pend = periph_req & ~ivm_pkg::SLOT_RESERVED_MASK;
        pend[ivm_pkg::SLOT_EXT6] = periph_req[ivm_pkg::SLOT_EXT6] | (HAS_CAN & can_wake);
        pend[ivm_pkg::SLOT_CAN] = HAS_CAN & can_req;
        pend[ivm_pkg::SLOT_FRT1_CLEAR] = frt1_clear;
        pend[ivm_pkg::SLOT_FRT1_ZERO] = frt1_zero;
        pend[ivm_pkg::SLOT_FRT2_CLEAR] = frt2_clear;
        pend[ivm_pkg::SLOT_FRT2_ZERO] = frt2_zero;
        pend[ivm_pkg::SLOT_FRT0_CLEAR] = frt0_clear;
        pend[ivm_pkg::SLOT_FRT0_ZERO] = frt0_zero;
        pend[ivm_pkg::SLOT_DELAY] = delay_bit;
    end

    // apb decode; level registers own the memory while selected
    assign lvl_hit = paddr >= ivm_pkg::OFS_LEVEL0 && paddr < ivm_pkg::OFS_LEVEL_END
        && paddr[1:0] == 2'b00;
    assign lvl_idx = 6'((paddr - ivm_pkg::OFS_LEVEL0) >> 2);
    assign apb_owns = psel && lvl_hit;
    assign acc = psel && penable;
    assign mem_addr = apb_owns ? lvl_idx : idx;
    assign mem_we = acc && pwrite && lvl_hit;
    assign mapped = lvl_hit || paddr == ivm_pkg::OFS_BASE || paddr == ivm_pkg::OFS_DELAY
        || paddr == ivm_pkg::OFS_STATUS || paddr == ivm_pkg::OFS_CLEAR
        || paddr == ivm_pkg::OFS_ENABLE || paddr == ivm_pkg::OFS_OFFER;

    level_mem #(
        .DEPTH(ivm_pkg::N_SLOTS),
        .WIDTH(ivm_pkg::LEVEL_W),
        .INIT(ivm_pkg::LEVEL_RESET)
    ) u_levels (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .addr(mem_addr),
        .we(mem_we),
        .wdata(pwdata[4:0]),
        .rdata(mem_rdata)
    );

    // scan: walk all level registers, keep the lowest level pending
    always_comb
    begin
        next_state = state;
        next_idx = idx;
        next_rd_valid = 1'b0;
        next_rd_idx = rd_idx;
        next_best_lvl = best_lvl;
        next_best_slot = best_slot;
        next_found = found;
        next_irq_vector = irq_vector;
        next_irq_level = irq_level;
        next_irq_fetch_addr = irq_fetch_addr;
        accept_ev = 1'b0;
        unique case (state)
            ivm_pkg::ST_IDLE:
            begin
                if (|pend)
                begin
                    next_state = ivm_pkg::ST_SCAN;
                    next_idx = 6'h00;
                    next_best_lvl = ivm_pkg::LEVEL_RESET;
                    next_found = 1'b0;
                end
            end
            ivm_pkg::ST_SCAN:
            begin
                if (!apb_owns && idx < 6'(ivm_pkg::N_SLOTS))
                begin
                    next_rd_valid = 1'b1;
                    next_rd_idx = idx;
                    next_idx = idx + 6'h01;
                end
                if (rd_valid && pend[rd_idx] && mem_rdata < next_best_lvl)
                begin
                    next_best_lvl = mem_rdata;
                    next_best_slot = rd_idx;
                    next_found = 1'b1;
                end
                if (rd_valid && rd_idx == 6'(ivm_pkg::N_SLOTS - 1))
                begin
                    next_state = ivm_pkg::ST_IDLE;
                    if (next_found && next_best_lvl < cpu_level_mask)
                    begin
                        next_state = ivm_pkg::ST_OFFER;
                        next_irq_vector = ivm_pkg::VEC_FIRST_HW + {2'b00, next_best_slot};
                        next_irq_level = next_best_lvl;
                        next_irq_fetch_addr = ivm_pkg::fetch_addr(vector_table_base,
                            next_irq_vector);
                    end
                end
            end
            ivm_pkg::ST_OFFER:
            begin
                if (cpu_ack)
                begin
                    accept_ev = 1'b1;
                    next_state = ivm_pkg::ST_IDLE;
                end
                else if (!pend[best_slot])
                    next_state = ivm_pkg::ST_IDLE;
            end
            default:
                next_state = ivm_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= ivm_pkg::ST_IDLE;
            idx <= 6'h00;
            rd_valid <= 1'b0;
            rd_idx <= 6'h00;
            best_lvl <= ivm_pkg::LEVEL_RESET;
            best_slot <= 6'h00;
            found <= 1'b0;
            irq_vector <= 8'h00;
            irq_level <= ivm_pkg::LEVEL_RESET;
            irq_fetch_addr <= 32'h0000_0000;
        end
        else
        begin
            state <= next_state;
            idx <= next_idx;
            rd_valid <= next_rd_valid;
            rd_idx <= next_rd_idx;
            best_lvl <= next_best_lvl;
            best_slot <= next_best_slot;
            found <= next_found;
            irq_vector <= next_irq_vector;
            irq_level <= next_irq_level;
            irq_fetch_addr <= next_irq_fetch_addr;
        end
    end

    assign cpu_irq_req = state == ivm_pkg::ST_OFFER;

    // software traps, no level involved
    always_comb
    begin
        next_trap_valid = trap_req && trap_num >= ivm_pkg::VEC_TRAP_FIRST;
        next_trap_vector = next_trap_valid ? trap_num : trap_vector;
        next_trap_fetch_addr = next_trap_valid
            ? ivm_pkg::fetch_addr(vector_table_base, trap_num) : trap_fetch_addr;
        trap_bad_ev = trap_req && !next_trap_valid;
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            trap_valid <= 1'b0;
            trap_vector <= 8'h00;
            trap_fetch_addr <= 32'h0000_0000;
        end
        else
        begin
            trap_valid <= next_trap_valid;
            trap_vector <= next_trap_vector;
            trap_fetch_addr <= next_trap_fetch_addr;
        end
    end

    // register file; reads take one wait cycle
    always_comb
    begin
        next_vector_table_base = vector_table_base;
        next_delay_bit = delay_bit;
        next_enable = enable;
        next_status = status;
        next_rd_wait = acc && !pwrite && !rd_wait;
        next_prdata = prdata;
        if (acc && pwrite)
        begin
            if (paddr == ivm_pkg::OFS_BASE)
                next_vector_table_base = {pwdata[31:2], 2'b00};
            if (paddr == ivm_pkg::OFS_DELAY)
                next_delay_bit = pwdata[0];
            if (paddr == ivm_pkg::OFS_ENABLE)
                next_enable = pwdata[2:0];
            if (paddr == ivm_pkg::OFS_CLEAR)
                next_status = status & ~pwdata[2:0];
        end
        // set wins over clear
        next_status[ivm_pkg::EV_ACCEPT] = next_status[ivm_pkg::EV_ACCEPT] | accept_ev;
        next_status[ivm_pkg::EV_TRAP] = next_status[ivm_pkg::EV_TRAP] | next_trap_valid;
        next_status[ivm_pkg::EV_TRAP_BAD] = next_status[ivm_pkg::EV_TRAP_BAD] | trap_bad_ev;
        if (acc && !pwrite && !rd_wait)
        begin
            if (lvl_hit)
                next_prdata = {27'h0, mem_rdata};
            else if (paddr == ivm_pkg::OFS_BASE)
                next_prdata = vector_table_base;
            else if (paddr == ivm_pkg::OFS_DELAY)
                next_prdata = {31'h0, delay_bit};
            else if (paddr == ivm_pkg::OFS_STATUS)
                next_prdata = {29'h0, status};
            else if (paddr == ivm_pkg::OFS_ENABLE)
                next_prdata = {29'h0, enable};
            else if (paddr == ivm_pkg::OFS_OFFER)
                next_prdata = {cpu_irq_req, 1'b0, state, 15'h0, irq_level, irq_vector};
            else
                next_prdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            vector_table_base <= ivm_pkg::BASE_RESET;
            delay_bit <= 1'b0;
            status <= ivm_pkg::EV_RESET;
            enable <= ivm_pkg::EV_RESET;
            rd_wait <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            vector_table_base <= next_vector_table_base;
            delay_bit <= next_delay_bit;
            status <= next_status;
            enable <= next_enable;
            rd_wait <= next_rd_wait;
            prdata <= next_prdata;
        end
    end

    assign pready = pwrite || rd_wait;
    assign pslverr = acc && pready && !mapped;
    assign irq = |(status & enable);

    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    a_trap_range: assert property (
        trap_req && trap_num >= 8'h50 |=> trap_valid && trap_vector == $past(trap_num))
        else $error("trap in range not taken");
    a_trap_addr: assert property (
        trap_valid |-> trap_vector >= 8'h50
        && trap_fetch_addr == $past(vector_table_base) + 32'h3FC - {trap_vector, 2'b00})
        else $error("trap fetch address wrong");
    a_vec22_shared: assert property (
        cpu_irq_req && irq_vector == 8'h16 |-> irq_level == $past(best_lvl, 1)
        && (periph_req[6] || (HAS_CAN && can_wake) || $past(cpu_irq_req)))
        else $error("vector 22 without line 6 or wake");
    a_can_absent: assert property (
        !HAS_CAN |-> !(cpu_irq_req && irq_vector == 8'h23))
        else $error("can vector on variant without can");
    a_delay_vec: assert property (
        cpu_irq_req && irq_vector == 8'h3F |-> irq_fetch_addr == vector_table_base + 32'h300)
        else $error("delayed vector offset wrong");
    // an offer that stays up was kept up by its own source in the cycle before
    a_frt1_clear: assert property (
        cpu_irq_req && $past(cpu_irq_req) && irq_vector == 8'h2B |-> $past(frt1_clear))
        else $error("vector 43 held without timer1 clear");
    a_frt1_zero: assert property (
        cpu_irq_req && $past(cpu_irq_req) && irq_vector == 8'h2C |-> $past(frt1_zero))
        else $error("vector 44 held without timer1 zero");
    a_frt2_clear: assert property (
        cpu_irq_req && $past(cpu_irq_req) && irq_vector == 8'h2D |-> $past(frt2_clear))
        else $error("vector 45 held without timer2 clear");
    a_frt2_zero: assert property (
        cpu_irq_req && $past(cpu_irq_req) && irq_vector == 8'h2E |-> $past(frt2_zero))
        else $error("vector 46 held without timer2 zero");
    a_frt0_clear: assert property (
        cpu_irq_req && $past(cpu_irq_req) && irq_vector == 8'h30 |-> $past(frt0_clear))
        else $error("vector 48 held without timer0 clear");
    a_frt0_zero: assert property (
        cpu_irq_req && $past(cpu_irq_req) && irq_vector == 8'h31 |-> $past(frt0_zero))
        else $error("vector 49 held without timer0 zero");
    a_rtos_never: assert property (
        (cpu_irq_req |-> irq_vector < 8'h40) and (trap_valid |-> trap_vector >= 8'h50))
        else $error("rtos vector requested");
    a_fetch_addr: assert property (
        $rose(cpu_irq_req) |-> irq_fetch_addr == vector_table_base + 32'h3FC
        - {irq_vector, 2'b00})
        else $error("irq fetch address wrong");

    c_accept: cover property (cpu_irq_req && cpu_ack);
    c_trap: cover property (trap_valid);
    c_wake: cover property (cpu_irq_req && irq_vector == 8'h16 && can_wake);
    c_lvl_read: cover property (acc && !pwrite && lvl_hit && pready);
endmodule

// ===== rtl/level_mem.sv
`timescale 1ns/1ps
module level_mem #(
    parameter int DEPTH = 48,
    parameter int WIDTH = 5,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // single port
    input wire logic [5:0] addr,
    input wire logic we,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_rdata;

    if (DEPTH > 64 || DEPTH < 1)
    begin : g_depth_check
        $error("level_mem depth out of range");
    end

    always_comb
    begin
        next_rdata = (int'(addr) < DEPTH) ? mem[addr] : INIT;
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata <= INIT;
            for (int i = 0; i < DEPTH; i++)
                mem[i] <= INIT;
        end
        else
        begin
            rdata <= next_rdata;
            if (we && int'(addr) < DEPTH)
                mem[addr] <= wdata;
        end
    end
endmodule

// ===== testbench/cpu_entry_model.sv
`timescale 1ns/1ps
module cpu_entry_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // offer from the mapper
    input wire logic cpu_irq_req,
    input wire logic [7:0] ack_delay,
    // acceptance
    output logic cpu_ack,
    output int taken
);
    logic [7:0] wait_cnt;
    logic [7:0] next_wait_cnt;
    logic next_cpu_ack;
    int next_taken;

    // acknowledge after a chosen number of offered cycles, one pulse per offer
    always_comb
    begin
        next_wait_cnt = 8'h00;
        next_cpu_ack = 1'b0;
        next_taken = taken;
        if (cpu_irq_req && !cpu_ack)
        begin
            next_wait_cnt = wait_cnt + 8'h01;
            if (wait_cnt >= ack_delay)
            begin
                next_cpu_ack = 1'b1;
                next_taken = taken + 1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            wait_cnt <= 8'h00;
            cpu_ack <= 1'b0;
            taken <= 0;
        end
        else
        begin
            wait_cnt <= next_wait_cnt;
            cpu_ack <= next_cpu_ack;
            taken <= next_taken;
        end
    end
endmodule

// ===== testbench/tb_interrupt_vector_map.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_interrupt_vector_map;
    logic clk_sys, nrst, psel, penable, pwrite, can_req, can_wake, trap_req;
    logic frt0_clear, frt0_zero, frt1_clear, frt1_zero, frt2_clear, frt2_zero;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, irq_fetch_addr, trap_fetch_addr, rd;
    logic [47:0] periph_req;
    logic [4:0] cpu_level_mask, irq_level;
    logic [7:0] irq_vector, trap_num, trap_vector, ack_delay;
    logic pready, pslverr, cpu_irq_req, cpu_ack, trap_valid, irq, nc_req, err;
    int mismatches, checks_done, taken;
    typedef struct {int src; int slot; logic [7:0] vec;} row_t;
    row_t rows [10];

    interrupt_vector_map #(.HAS_CAN(1'b1)) dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .periph_req(periph_req), .can_req(can_req),
        .can_wake(can_wake), .frt0_clear(frt0_clear), .frt0_zero(frt0_zero),
        .frt1_clear(frt1_clear), .frt1_zero(frt1_zero), .frt2_clear(frt2_clear),
        .frt2_zero(frt2_zero), .cpu_level_mask(cpu_level_mask), .cpu_irq_req(cpu_irq_req),
        .irq_vector(irq_vector), .irq_level(irq_level), .irq_fetch_addr(irq_fetch_addr),
        .cpu_ack(cpu_ack), .trap_req(trap_req), .trap_num(trap_num), .trap_valid(trap_valid),
        .trap_vector(trap_vector), .trap_fetch_addr(trap_fetch_addr), .irq(irq));
    // variant without the can controller, same stimulus
    interrupt_vector_map #(.HAS_CAN(1'b0)) dut_nocan (.clk_sys(clk_sys), .nrst(nrst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(), .pready(), .pslverr(), .periph_req(periph_req), .can_req(can_req),
        .can_wake(can_wake), .frt0_clear(frt0_clear), .frt0_zero(frt0_zero),
        .frt1_clear(frt1_clear), .frt1_zero(frt1_zero), .frt2_clear(frt2_clear),
        .frt2_zero(frt2_zero), .cpu_level_mask(cpu_level_mask), .cpu_irq_req(nc_req),
        .irq_vector(), .irq_level(), .irq_fetch_addr(), .cpu_ack(cpu_ack), .trap_req(trap_req),
        .trap_num(trap_num), .trap_valid(), .trap_vector(), .trap_fetch_addr(), .irq());
    cpu_entry_model partner (.clk_sys(clk_sys), .nrst(nrst), .cpu_irq_req(cpu_irq_req),
        .ack_delay(ack_delay), .cpu_ack(cpu_ack), .taken(taken));

    task end_of_test;
        $display("mismatches %0d checks_done %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        `CHK("pready", 1'b1, pready)
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task set_src(input int s, input logic v);
        if (s == 3)
            apb(1'b1, 12'h004, {31'h0, v});
        else
        begin
            @(posedge clk_sys);
            case (s)
                0: periph_req[6] <= v;
                1: can_wake <= v;
                2: can_req <= v;
                4: frt1_clear <= v;
                5: frt1_zero <= v;
                6: frt2_clear <= v;
                7: frt2_zero <= v;
                8: frt0_clear <= v;
                default: frt0_zero <= v;
            endcase
        end
    endtask

    task wait_req(input logic v);
        int n;
        n = 0;
        do
        begin
            @(negedge clk_sys);
            n++;
        end
        while (cpu_irq_req !== v && n < 300);
        `CHK("cpu_irq_req", v, cpu_irq_req)
    endtask

    task trap(input logic [7:0] n, input logic ok, input logic [31:0] base);
        @(posedge clk_sys);
        trap_req <= 1'b1;
        trap_num <= n;
        @(posedge clk_sys);
        trap_req <= 1'b0;
        @(negedge clk_sys);
        `CHK("trap_valid", ok, trap_valid)
        if (ok)
        begin
            `CHK("trap_vector", n, trap_vector)
            `CHK("trap_fetch_addr", base + 32'h3FC - {22'h0, n, 2'b00}, trap_fetch_addr)
        end
    endtask

    task chk_reg(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK("register", e, rd)
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    initial
    begin
        repeat (40000) @(posedge clk_sys);
        mismatches++;
        end_of_test;
    end

    initial
    begin
        {nrst, psel, penable, pwrite, can_req, can_wake, trap_req} = 7'h00;
        {frt0_clear, frt0_zero, frt1_clear, frt1_zero, frt2_clear, frt2_zero} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        periph_req = 48'h0;
        trap_num = 8'h00;
        ack_delay = 8'h00;
        cpu_level_mask = 5'h1F;
        rows = '{'{0, 6, 8'h16}, '{1, 6, 8'h16}, '{2, 19, 8'h23}, '{3, 47, 8'h3F},
            '{4, 27, 8'h2B}, '{5, 28, 8'h2C}, '{6, 29, 8'h2D}, '{7, 30, 8'h2E},
            '{8, 32, 8'h30}, '{9, 33, 8'h31}};
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        chk_reg(12'h000, 32'h000FFC00);
        chk_reg(12'h100, 32'h1F);
        foreach (rows[i])
        begin
            ack_delay <= 8'(i * 3);
            apb(1'b1, 12'h100 + 12'(4 * rows[i].slot), 32'(i + 1));
            set_src(rows[i].src, 1'b1);
            wait_req(1'b1);
            `CHK("irq_vector", rows[i].vec, irq_vector)
            `CHK("irq_level", 5'(i + 1), irq_level)
            `CHK("irq_fetch_addr", 32'h000FFFFC - {22'h0, rows[i].vec, 2'b00}, irq_fetch_addr)
            if (rows[i].src == 1 || rows[i].src == 2)
                `CHK("nocan_req", 1'b0, nc_req)
            wait_req(1'b0);
            set_src(rows[i].src, 1'b0);
        end
        `CHK("taken", 10, taken)
        apb(1'b1, 12'h010, 32'h4);
        trap(8'h50, 1'b1, 32'h000FFC00);
        trap(8'hFF, 1'b1, 32'h000FFC00);
        trap(8'h4F, 1'b0, 32'h000FFC00);
        trap(8'h40, 1'b0, 32'h000FFC00);
        `CHK("irq", 1'b1, irq)
        trap(8'h41, 1'b0, 32'h000FFC00);
        chk_reg(12'h008, 32'h7);
        apb(1'b1, 12'h00C, 32'h7);
        @(negedge clk_sys);
        `CHK("irq", 1'b0, irq)
        chk_reg(12'h008, 32'h0);
        apb(1'b1, 12'h010, 32'h0);
        trap(8'h40, 1'b0, 32'h000FFC00);
        `CHK("irq", 1'b0, irq)
        apb(1'b1, 12'h010, 32'h4);
        @(negedge clk_sys);
        `CHK("irq", 1'b1, irq)
        chk_reg(12'h010, 32'h4);
        apb(1'b1, 12'h00C, 32'h4);
        apb(1'b1, 12'h000, 32'h00010000);
        trap(8'h50, 1'b1, 32'h00010000);
        apb(1'b0, 12'h020, 32'h0);
        `CHK("pslverr", 1'b1, err)
        `CHK("unmapped", 32'h0, rd)
        // idle offer register keeps the last vector and level
        repeat (60) @(posedge clk_sys);
        chk_reg(12'h014, 32'h0000_0A31);
        end_of_test;
    end
endmodule
